// ==== tsc_regs.svh ====
`ifndef TSC_REGS_SVH
`define TSC_REGS_SVH

// Register byte offsets
`define TSC_OFF_CTRL       8'h00
`define TSC_OFF_STATUS     8'h04
`define TSC_OFF_POS        8'h08
`define TSC_OFF_CUE        8'h0C
`define TSC_AXI_AW         8
`define TSC_AXI_DW         32

// CTRL bits, write-only pulses
`define TSC_CTRL_CUE       0
`define TSC_CTRL_SEARCH    1
`define TSC_CTRL_ABORT     2

// STATUS bits
`define TSC_ST_BUSY        0
`define TSC_ST_YIELD       1
`define TSC_ST_PLAY        2
`define TSC_ST_OUTWIN      3
`define TSC_ST_STEP_LO     4
`define TSC_ST_STEP_HI     5
`define TSC_ST_HALVE       6

// AXI responses
`define TSC_RESP_OKAY      2'h0
`define TSC_RESP_SLVERR    2'h2

// Pin vector layout
`define TSC_PIN_W          9
`define TSC_PIN_CUE        0
`define TSC_PIN_SEARCH     1
`define TSC_PIN_HALVE      2
`define TSC_PIN_STOP       3
`define TSC_PIN_PLAY       4
`define TSC_PIN_REW        5
`define TSC_PIN_FFWD       6
`define TSC_PIN_TACH       7
`define TSC_PIN_REV        8

// Position and search window, in tach pulses
`define TSC_POS_W          16
`define TSC_POS_RST        16'h0000
`define TSC_POS_ONE        16'h0001
`define TSC_WIN_SPAN       16'h2000
`define TSC_WIN_HALF       16'h1000
`define TSC_DIST_STEP0     16'h0400
`define TSC_DIST_STEP1     16'h0100
`define TSC_DIST_STEP2     16'h0040

// Shuttle speeds in in/s
`define TSC_SPD_W          9
`define TSC_SPD_390        9'h186
`define TSC_SPD_195        9'h0C3
`define TSC_SPD_97         9'h061
`define TSC_SPD_48         9'h030
`define TSC_SPD_NONE       9'h000
`define TSC_HALF_SHIFT     1

`endif

// ==== tsc_pkg.sv ====
package tsc_pkg;

   typedef enum logic [1:0] {
      TSC_IDLE,
      TSC_RUN,
      TSC_YIELD
   } tsc_state_t;

   typedef enum logic [1:0] {
      TSC_STEP_390,
      TSC_STEP_195,
      TSC_STEP_97,
      TSC_STEP_48
   } tsc_step_t;

endpackage : tsc_pkg

// ==== tsc_sync2.sv ====
`timescale 1ns/1ps

module tsc_sync2 #(
   parameter int WIDTH = 1
) (
   input  wire logic             clk,
   input  wire logic             srst,
   input  wire logic             ce,
   input  wire logic [WIDTH-1:0] d,
   output logic      [WIDTH-1:0] q
);

   logic [WIDTH-1:0] meta_q;

   // First stage feeds only the second stage
   always_ff @(posedge clk) begin
      if (srst) begin
         meta_q <= '0;
         q      <= '0;
      end else if (ce) begin
         meta_q <= d;
         q      <= meta_q;
      end
   end

endmodule : tsc_sync2

// ==== tsc_search_ctrl.sv ====
// Notes on behaviour
// - A search is only run while the cue lies within a window of 8192 tach pulses about it.
// - Nearing the cue the shuttle speed steps down through 390, 195, 97 and 48 in/s.
// - Pressing cue store records the present tape position as the cue target.
// - Pressing search starts driving the transport toward the stored cue.
// - With the rear descent toggle set every descent speed step is halved.
// - Outside a running search all transport control outputs stay released.
// - On arrival with no play exit requested the transport is commanded into stop.
// - A play press any time after search is commanded is latched and gives play on arrival.
// - The latched play exit is cleared when the search ends.
// - A stop press during a search aborts it and hands control back to the operator.
// - Holding rewind or fast forward suspends the search, which resumes on release.
// - Only the tach pulses and steady levels come in; all timing is made internally.
//
// Implementation choices: the register addresses and the AXI4-Lite slave port.
`timescale 1ns/1ps
`include "tsc_regs.svh"

module tsc_search_ctrl (
   input  wire logic                    ref_clk,
   input  wire logic                    srst,
   input  wire logic                    ce,
   input  wire logic                    cueStoreBtn,
   input  wire logic                    searchBtn,
   input  wire logic                    halveSw,
   input  wire logic                    stopBtn,
   input  wire logic                    playBtn,
   input  wire logic                    rewindBtn,
   input  wire logic                    ffwdBtn,
   input  wire logic                    tachPulse,
   input  wire logic                    tapeRev,
   output logic                         ctrlActive,
   output logic                         shuttleFwd,
   output logic                         shuttleRev,
   output logic [`TSC_SPD_W-1:0]        shuttleSpeed,
   output logic                         stopCmd,
   output logic                         playCmd,
   input  wire logic [`TSC_AXI_AW-1:0]  s_axi_awaddr,
   input  wire logic                    s_axi_awvalid,
   output logic                         s_axi_awready,
   input  wire logic [`TSC_AXI_DW-1:0]  s_axi_wdata,
   input  wire logic [3:0]              s_axi_wstrb,
   input  wire logic                    s_axi_wvalid,
   output logic                         s_axi_wready,
   output logic [1:0]                   s_axi_bresp,
   output logic                         s_axi_bvalid,
   input  wire logic                    s_axi_bready,
   input  wire logic [`TSC_AXI_AW-1:0]  s_axi_araddr,
   input  wire logic                    s_axi_arvalid,
   output logic                         s_axi_arready,
   output logic [`TSC_AXI_DW-1:0]       s_axi_rdata,
   output logic [1:0]                   s_axi_rresp,
   output logic                         s_axi_rvalid,
   input  wire logic                    s_axi_rready
);

   // Pin synchronisation and edges
   logic [`TSC_PIN_W-1:0] pinRaw;
   logic [`TSC_PIN_W-1:0] pinSync;
   logic [`TSC_PIN_W-1:0] pinDly_q;
   logic [`TSC_PIN_W-1:0] pinRise;

   assign pinRaw = {tapeRev, tachPulse, ffwdBtn, rewindBtn, playBtn,
                    stopBtn, halveSw, searchBtn, cueStoreBtn};

   // Every input is a level or the tach train; nothing is clocked by the transport
   tsc_sync2 #(
      .WIDTH (`TSC_PIN_W)
   ) uSync (
      .clk  (ref_clk),
      .srst (srst),
      .ce   (ce),
      .d    (pinRaw),
      .q    (pinSync)
   );

   always_ff @(posedge ref_clk) begin
      if (srst) begin
         pinDly_q <= '0;
      end else if (ce) begin
         pinDly_q <= pinSync;
      end
   end

   assign pinRise = pinSync & ~pinDly_q;

   // Speed selection helpers
   function automatic tsc_pkg::tsc_step_t stepOf(input logic [`TSC_POS_W-1:0] m);
      if (m > `TSC_DIST_STEP0) begin
         stepOf = tsc_pkg::TSC_STEP_390;
      end else if (m > `TSC_DIST_STEP1) begin
         stepOf = tsc_pkg::TSC_STEP_195;
      end else if (m > `TSC_DIST_STEP2) begin
         stepOf = tsc_pkg::TSC_STEP_97;
      end else begin
         stepOf = tsc_pkg::TSC_STEP_48;
      end
   endfunction : stepOf

   function automatic logic [`TSC_SPD_W-1:0] speedOf(input tsc_pkg::tsc_step_t s,
                                                      input logic half);
      logic [`TSC_SPD_W-1:0] v;
      v = `TSC_SPD_48;
      case (s)
         tsc_pkg::TSC_STEP_390: v = `TSC_SPD_390;
         tsc_pkg::TSC_STEP_195: v = `TSC_SPD_195;
         tsc_pkg::TSC_STEP_97:  v = `TSC_SPD_97;
         default:               v = `TSC_SPD_48;
      endcase
      speedOf = half ? (v >> `TSC_HALF_SHIFT) : v;
   endfunction : speedOf

   // Position tracking
   logic [`TSC_POS_W-1:0] pos_q;
   logic [`TSC_POS_W-1:0] pos_d;
   logic [`TSC_POS_W-1:0] cue_q;
   logic [`TSC_POS_W-1:0] cue_d;
   logic [`TSC_POS_W-1:0] diff;
   logic [`TSC_POS_W-1:0] mag;
   logic                  diffNeg;
   logic                  outWin;
   logic                  arrived;
   tsc_pkg::tsc_step_t    step;

   assign pos_d = pinSync[`TSC_PIN_REV] ? pos_q - `TSC_POS_ONE
                                        : pos_q + `TSC_POS_ONE;

   // Wrapping difference; the window keeps it far from the wrap point
   assign diff    = cue_q - pos_q;
   assign diffNeg = diff[`TSC_POS_W-1];
   assign mag     = diffNeg ? (~diff + `TSC_POS_ONE) : diff;
   assign outWin  = mag > `TSC_WIN_HALF;
   assign arrived = diff == `TSC_POS_RST;
   assign step    = stepOf(mag);

   // Software and pin requests
   logic                  wrFire;
   logic                  wrCtrl;
   logic                  wrStatus;
   logic                  wrCue;
   logic [`TSC_AXI_AW-1:0] awAddr_q;
   logic [`TSC_AXI_DW-1:0] wData_q;
   logic [3:0]            wStrb_q;
   logic                  swCue;
   logic                  swSearch;
   logic                  swAbort;
   logic                  cueReq;
   logic                  startReq;
   logic                  abortReq;
   logic                  yieldHeld;

   assign swCue     = wrCtrl & wStrb_q[0] & wData_q[`TSC_CTRL_CUE];
   assign swSearch  = wrCtrl & wStrb_q[0] & wData_q[`TSC_CTRL_SEARCH];
   assign swAbort   = wrCtrl & wStrb_q[0] & wData_q[`TSC_CTRL_ABORT];
   assign cueReq    = pinRise[`TSC_PIN_CUE] | swCue;
   assign startReq  = pinRise[`TSC_PIN_SEARCH] | swSearch;
   assign abortReq  = pinRise[`TSC_PIN_STOP] | swAbort;
   assign yieldHeld = pinSync[`TSC_PIN_REW] | pinSync[`TSC_PIN_FFWD];

   // Search sequencer
   tsc_pkg::tsc_state_t state_q;
   tsc_pkg::tsc_state_t state_d;
   logic                finish;
   logic                refuse;

   always_comb begin
      state_d = state_q;
      finish  = 1'b0;
      refuse  = 1'b0;
      case (state_q)
         tsc_pkg::TSC_IDLE: begin
            if (startReq) begin
               if (outWin) begin
                  refuse = 1'b1;
               end else if (arrived) begin
                  finish = 1'b1;
               end else begin
                  // Held transport button at start: begin yielded, no drive until release
                  state_d = yieldHeld ? tsc_pkg::TSC_YIELD : tsc_pkg::TSC_RUN;
               end
            end
         end
         tsc_pkg::TSC_RUN: begin
            if (abortReq) begin
               state_d = tsc_pkg::TSC_IDLE;
            end else if (arrived) begin
               finish  = 1'b1;
               state_d = tsc_pkg::TSC_IDLE;
            end else if (outWin) begin
               refuse  = 1'b1;
               state_d = tsc_pkg::TSC_IDLE;
            end else if (yieldHeld) begin
               state_d = tsc_pkg::TSC_YIELD;
            end
         end
         tsc_pkg::TSC_YIELD: begin
            if (abortReq) begin
               state_d = tsc_pkg::TSC_IDLE;
            end else if (!yieldHeld) begin
               state_d = tsc_pkg::TSC_RUN;
            end
         end
         default: begin
            state_d = tsc_pkg::TSC_IDLE;
         end
      endcase
   end

   // Play exit latch; a press that lands on the arrival edge is used at once
   logic busy;
   logic playSet;
   logic playExit;
   logic searchEnds;
   logic playLat_q;
   logic playLat_d;
   logic outWin_q;
   logic outWin_d;

   assign busy       = state_q != tsc_pkg::TSC_IDLE;
   assign playSet    = pinRise[`TSC_PIN_PLAY] & (busy | startReq);
   assign playExit   = playLat_q | playSet;
   assign searchEnds = (busy | startReq) & (state_d == tsc_pkg::TSC_IDLE);
   assign playLat_d  = searchEnds ? 1'b0 : (playLat_q | playSet);
   assign outWin_d   = refuse | (outWin_q & ~(wrStatus & wStrb_q[0]
                                             & wData_q[`TSC_ST_OUTWIN]));

   // Transport drive; released unless running
   logic                  drive;
   logic                  ctrlActive_d;
   logic                  shuttleFwd_d;
   logic                  shuttleRev_d;
   logic [`TSC_SPD_W-1:0] shuttleSpeed_d;
   logic                  stopCmd_d;
   logic                  playCmd_d;

   assign drive          = state_d == tsc_pkg::TSC_RUN;
   assign ctrlActive_d   = drive | finish;
   assign shuttleFwd_d   = drive & ~diffNeg;
   assign shuttleRev_d   = drive & diffNeg;
   assign shuttleSpeed_d = drive ? speedOf(step, pinSync[`TSC_PIN_HALVE])
                                 : `TSC_SPD_NONE;
   assign stopCmd_d      = finish & ~playExit;
   assign playCmd_d      = finish & playExit;

   assign cue_d = wrCue ? {wStrb_q[1] ? wData_q[15:8] : cue_q[15:8],
                           wStrb_q[0] ? wData_q[7:0]  : cue_q[7:0]}
                        : pos_q;

   always_ff @(posedge ref_clk) begin
      if (srst) begin
         state_q   <= tsc_pkg::TSC_IDLE;
         pos_q     <= `TSC_POS_RST;
         cue_q     <= `TSC_POS_RST;
         playLat_q <= 1'b0;
         outWin_q  <= 1'b0;
      end else if (ce) begin
         state_q   <= state_d;
         playLat_q <= playLat_d;
         outWin_q  <= outWin_d;
         if (pinRise[`TSC_PIN_TACH]) begin
            pos_q <= pos_d;
         end
         if (cueReq | wrCue) begin
            cue_q <= cue_d;
         end
      end
   end

   always_ff @(posedge ref_clk) begin
      if (srst) begin
         ctrlActive   <= 1'b0;
         shuttleFwd   <= 1'b0;
         shuttleRev   <= 1'b0;
         shuttleSpeed <= `TSC_SPD_NONE;
         stopCmd      <= 1'b0;
         playCmd      <= 1'b0;
      end else if (ce) begin
         ctrlActive   <= ctrlActive_d;
         shuttleFwd   <= shuttleFwd_d;
         shuttleRev   <= shuttleRev_d;
         shuttleSpeed <= shuttleSpeed_d;
         stopCmd      <= stopCmd_d;
         playCmd      <= playCmd_d;
      end
   end

   // AXI4-Lite write path: address and data held apart, then joined
   logic awHeld_q;
   logic wHeld_q;
   logic awTake;
   logic wTake;
   logic awHeld_d;
   logic wHeld_d;
   logic bvalid_d;
   logic wrHit;

   assign awTake   = s_axi_awvalid & s_axi_awready;
   assign wTake    = s_axi_wvalid & s_axi_wready;
   assign wrFire   = awHeld_q & wHeld_q & ~s_axi_bvalid;
   assign wrCtrl   = wrFire & (awAddr_q == `TSC_OFF_CTRL);
   assign wrStatus = wrFire & (awAddr_q == `TSC_OFF_STATUS);
   assign wrCue    = wrFire & (awAddr_q == `TSC_OFF_CUE);
   assign wrHit    = wrCtrl | wrStatus | wrCue | (awAddr_q == `TSC_OFF_POS);
   assign awHeld_d = (awHeld_q & ~wrFire) | awTake;
   assign wHeld_d  = (wHeld_q & ~wrFire) | wTake;
   assign bvalid_d = wrFire | (s_axi_bvalid & ~s_axi_bready);

   always_ff @(posedge ref_clk) begin
      if (srst) begin
         awHeld_q      <= 1'b0;
         wHeld_q       <= 1'b0;
         awAddr_q      <= '0;
         wData_q       <= '0;
         wStrb_q       <= '0;
         s_axi_awready <= 1'b0;
         s_axi_wready  <= 1'b0;
         s_axi_bvalid  <= 1'b0;
         s_axi_bresp   <= `TSC_RESP_OKAY;
      end else if (ce) begin
         awHeld_q      <= awHeld_d;
         wHeld_q       <= wHeld_d;
         s_axi_awready <= ~awHeld_d & ~bvalid_d;
         s_axi_wready  <= ~wHeld_d & ~bvalid_d;
         s_axi_bvalid  <= bvalid_d;
         if (awTake) begin
            awAddr_q <= s_axi_awaddr;
         end
         if (wTake) begin
            wData_q <= s_axi_wdata;
            wStrb_q <= s_axi_wstrb;
         end
         if (wrFire) begin
            s_axi_bresp <= wrHit ? `TSC_RESP_OKAY : `TSC_RESP_SLVERR;
         end
      end
   end

   // AXI4-Lite read path, one cycle from address to data
   logic                   arTake;
   logic                   rdHit;
   logic [`TSC_AXI_DW-1:0] rdMux;
   logic [`TSC_AXI_DW-1:0] statusWord;

   assign arTake     = s_axi_arvalid & s_axi_arready;
   assign statusWord = {25'h0000000, pinSync[`TSC_PIN_HALVE], step,
                        outWin_q, playLat_q, state_q == tsc_pkg::TSC_YIELD, busy};
   assign rdHit      = (s_axi_araddr == `TSC_OFF_CTRL) | (s_axi_araddr == `TSC_OFF_STATUS)
                     | (s_axi_araddr == `TSC_OFF_POS) | (s_axi_araddr == `TSC_OFF_CUE);
   assign rdMux      = (s_axi_araddr == `TSC_OFF_STATUS) ? statusWord
                     : (s_axi_araddr == `TSC_OFF_POS)    ? {16'h0000, pos_q}
                     : (s_axi_araddr == `TSC_OFF_CUE)    ? {16'h0000, cue_q}
                     : 32'h00000000;

   always_ff @(posedge ref_clk) begin
      if (srst) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid  <= 1'b0;
         s_axi_rdata   <= '0;
         s_axi_rresp   <= `TSC_RESP_OKAY;
      end else if (ce) begin
         if (arTake) begin
            s_axi_rvalid  <= 1'b1;
            s_axi_arready <= 1'b0;
            s_axi_rdata   <= rdMux;
            s_axi_rresp   <= rdHit ? `TSC_RESP_OKAY : `TSC_RESP_SLVERR;
         end else if (s_axi_rvalid & s_axi_rready) begin
            s_axi_rvalid  <= 1'b0;
            s_axi_arready <= 1'b1;
         end else if (!s_axi_rvalid) begin
            s_axi_arready <= 1'b1;
         end
      end
   end

endmodule : tsc_search_ctrl

// ==== tstcc_search_properties.sv ====
`timescale 1ns/1ps
`include "tsc_regs.svh"

module tstcc_checker (
   input wire logic       ref_clk,
   input wire logic       srst,
   input wire logic       halveSw,
   input wire logic       stopBtn,
   input wire logic       rewindBtn,
   input wire logic       ffwdBtn,
   input wire logic       ctrlActive,
   input wire logic       shuttleFwd,
   input wire logic       shuttleRev,
   input wire logic [8:0] shuttleSpeed,
   input wire logic       stopCmd,
   input wire logic       playCmd,
   input wire logic       s_axi_arvalid,
   input wire logic       s_axi_arready,
   input wire logic       s_axi_rvalid
);
   default clocking @(posedge ref_clk); endclocking
   default disable iff (srst);
   wire drive = shuttleFwd || shuttleRev;
   wire done  = stopCmd || playCmd;

   a_idle_released: assert property (
      !ctrlActive |-> !drive && shuttleSpeed == 9'h000)
      else $error("transport driven with no search running");
   a_one_dir: assert property (!(shuttleFwd && shuttleRev))
      else $error("both shuttle directions driven");
   a_speed_steps: assert property (
      drive |-> shuttleSpeed inside {9'h186, 9'h0C3, 9'h061, 9'h030, 9'h018})
      else $error("shuttle speed off the step table");
   // Six cycles covers the two-flop sync plus the output register
   a_halve_caps: assert property (
      halveSw [*6] ##0 drive |-> shuttleSpeed <= 9'h0C3)
      else $error("halved descent speed exceeded");
   a_one_exit: assert property (!(stopCmd && playCmd))
      else $error("stop and play commanded together");
   a_exit_pulse: assert property (
      done |=> !done && !ctrlActive && !drive)
      else $error("exit command not a single closing pulse");
   a_stop_aborts: assert property (
      ctrlActive && $rose(stopBtn) |-> ##[1:6] !ctrlActive)
      else $error("stop press did not end the search");
   a_stop_silent: assert property (
      ctrlActive && $rose(stopBtn) |-> !done [*6])
      else $error("stop abort gave an exit command");
   a_yield_holds: assert property (
      (rewindBtn || ffwdBtn) [*6] |-> !drive)
      else $error("shuttle driven while a transport button is held");
   a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
      else $error("read answer late");

   c_stop_exit: cover property (stopCmd);
   c_play_exit: cover property (playCmd);
   c_yield: cover property ((rewindBtn || ffwdBtn) && !drive ##[1:6] drive);
endmodule : tstcc_checker

bind tsc_search_ctrl tstcc_checker u_chk (
   .ref_clk, .srst, .halveSw, .stopBtn, .rewindBtn, .ffwdBtn, .ctrlActive, .shuttleFwd,
   .shuttleRev, .shuttleSpeed, .stopCmd, .playCmd, .s_axi_arvalid, .s_axi_arready,
   .s_axi_rvalid
);

// ==== tstcc_transport.sv ====
`timescale 1ns/1ps

module tstcc_transport (
   input wire logic ref_clk,
   input wire logic srst,
   input wire logic shuttleFwd,
   input wire logic shuttleRev,
   input wire logic slowTach,
   output logic     tachPulse,
   output logic     tapeRev
);
   logic [3:0] phase_q;
   wire        moving = shuttleFwd || shuttleRev;
   wire [3:0]  lastPh = slowTach ? 4'hF : 4'h9;

   // A pulse starts only while driven, so the tape stops on the cue
   always_ff @(posedge ref_clk) begin
      if (srst) begin
         phase_q <= 4'h0;
         tapeRev <= 1'b0;
      end else if (phase_q != 4'h0 || moving) begin
         phase_q <= (phase_q == lastPh) ? 4'h0 : phase_q + 4'h1;
         if (phase_q == 4'h0)
            tapeRev <= shuttleRev;
      end
   end

   // Only the tach train and a steady direction level go back
   assign tachPulse = (phase_q >= 4'h2) && (phase_q <= 4'h5);
endmodule : tstcc_transport

// ==== test_tape_search_to_cue_controller.sv ====
`timescale 1ns/1ps
`include "tsc_regs.svh"

module test_tape_search_to_cue_controller;
   localparam int CUE = 0, SRCH = 1, HALVE = 2, STOP = 3, PLAY = 4, REW = 5, FFWD = 6;
   logic        ref_clk, srst, slowTach, tachPulse, tapeRev;
   logic        ctrlActive, shuttleFwd, shuttleRev, stopCmd, playCmd;
   logic [6:0]  btn;
   logic [8:0]  shuttleSpeed;
   logic [7:0]  s_axi_awaddr, s_axi_araddr;
   logic [31:0] s_axi_wdata, s_axi_rdata;
   logic [3:0]  s_axi_wstrb;
   logic [1:0]  s_axi_bresp, s_axi_rresp;
   logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
   logic        s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
   logic [8:0]  spdSeen[$];
   int          n_mismatch, checks, nStop, nPlay;

   initial begin
      ref_clk = 1'b0;
      forever #5 ref_clk = ~ref_clk;
   end

   tsc_search_ctrl dut (
      .ref_clk, .srst, .ce(1'b1), .cueStoreBtn(btn[CUE]), .searchBtn(btn[SRCH]),
      .halveSw(btn[HALVE]), .stopBtn(btn[STOP]), .playBtn(btn[PLAY]), .rewindBtn(btn[REW]),
      .ffwdBtn(btn[FFWD]), .tachPulse, .tapeRev, .ctrlActive, .shuttleFwd, .shuttleRev,
      .shuttleSpeed, .stopCmd, .playCmd, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
      .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
      .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
      .s_axi_rresp, .s_axi_rvalid, .s_axi_rready
   );
   tstcc_transport far (
      .ref_clk, .srst, .shuttleFwd, .shuttleRev, .slowTach, .tachPulse, .tapeRev
   );

   always @(posedge ref_clk) begin
      if (stopCmd === 1'b1)
         nStop++;
      if (playCmd === 1'b1)
         nPlay++;
      if (ctrlActive === 1'b1 && shuttleSpeed !== 9'h000 &&
          (spdSeen.size() == 0 || spdSeen[$] !== shuttleSpeed))
         spdSeen.push_back(shuttleSpeed);
   end

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : check

   task automatic results;
      if (n_mismatch == 0 && checks > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask : results

   task automatic axiWr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
      bit busy;
      busy = 1'b1;
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_wstrb <= 4'hF;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      while (busy) begin
         @(posedge ref_clk);
         if (s_axi_awvalid && s_axi_awready)
            s_axi_awvalid <= 1'b0;
         if (s_axi_wvalid && s_axi_wready)
            s_axi_wvalid <= 1'b0;
         if (s_axi_bvalid === 1'b1) begin
            r = s_axi_bresp;
            s_axi_bready <= 1'b0;
            busy = 1'b0;
         end
      end
      @(posedge ref_clk);
   endtask : axiWr

   task automatic axiRd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
      bit busy;
      busy = 1'b1;
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      while (busy) begin
         @(posedge ref_clk);
         if (s_axi_arvalid && s_axi_arready)
            s_axi_arvalid <= 1'b0;
         if (s_axi_rvalid === 1'b1) begin
            d = s_axi_rdata;
            r = s_axi_rresp;
            s_axi_rready <= 1'b0;
            busy = 1'b0;
         end
      end
      @(posedge ref_clk);
   endtask : axiRd

   // Held four cycles: pins narrower than one cycle may be missed
   task automatic press(input int i);
      btn[i] <= 1'b1;
      repeat (4) @(posedge ref_clk);
      btn[i] <= 1'b0;
      repeat (4) @(posedge ref_clk);
   endtask : press

   task automatic search(input logic [15:0] cue);
      logic [1:0] r;
      axiWr(`TSC_OFF_CUE, {16'h0000, cue}, r);
      spdSeen.delete();
      nStop = 0;
      nPlay = 0;
      press(SRCH);
   endtask : search

   task automatic waitIdle;
      while (ctrlActive !== 1'b0)
         @(posedge ref_clk);
   endtask : waitIdle

   task automatic chkEnd(input int s, input int p, input logic [8:0] e[4], input int n);
      check(nStop, s);
      check(nPlay, p);
      check(spdSeen.size(), n);
      for (int k = 0; k < n && k < spdSeen.size(); k++)
         check(spdSeen[k], e[k]);
   endtask : chkEnd

   task automatic regsTest;
      logic [31:0] d;
      logic [1:0]  r;
      // Idle on the cue: nothing busy, step code 3 for the slowest step
      axiRd(`TSC_OFF_STATUS, d, r);
      check(d, 32'h0000_0030);
      axiRd(8'h10, d, r);
      check({d, r}, {32'h0000_0000, `TSC_RESP_SLVERR});
      axiWr(8'h14, 32'h0000_0006, r);
      check(r, `TSC_RESP_SLVERR);
      axiWr(`TSC_OFF_POS, 32'h0000_1234, r);
      axiRd(`TSC_OFF_POS, d, r);
      check(d, 32'h0000_0000);
   endtask : regsTest

   task automatic fwdTest;
      logic [31:0] d;
      logic [1:0]  r;
      search(16'h0500);
      waitIdle();
      chkEnd(1, 0, '{9'h186, 9'h0C3, 9'h061, 9'h030}, 4);
      axiRd(`TSC_OFF_POS, d, r);
      check(d, 32'h0000_0500);
      axiWr(`TSC_OFF_CUE, 32'h0000_0000, r);
      press(CUE);
      axiRd(`TSC_OFF_CUE, d, r);
      check(d, 32'h0000_0500);
   endtask : fwdTest

   task automatic playTest;
      btn[HALVE] <= 1'b1;
      repeat (4) @(posedge ref_clk);
      search(16'h0000);
      check(shuttleRev, 1'b1);
      repeat (20) @(posedge ref_clk);
      press(PLAY);
      waitIdle();
      chkEnd(0, 1, '{9'h0C3, 9'h061, 9'h030, 9'h018}, 4);
      btn[HALVE] <= 1'b0;
      slowTach <= 1'b1;
      search(16'h0080);
      waitIdle();
      chkEnd(1, 0, '{9'h061, 9'h030, 9'h000, 9'h000}, 2);
      slowTach <= 1'b0;
   endtask : playTest

   task automatic stopTest;
      logic [31:0] d;
      logic [1:0]  r;
      search(16'h0500);
      repeat (50) @(posedge ref_clk);
      press(STOP);
      check(ctrlActive, 1'b0);
      axiRd(`TSC_OFF_STATUS, d, r);
      check(d[`TSC_ST_BUSY], 1'b0);
      check(nStop + nPlay, 0);
   endtask : stopTest

   task automatic yieldTest;
      search(16'h0500);
      for (int i = REW; i <= FFWD; i++) begin
         btn[i] <= 1'b1;
         repeat (10) @(posedge ref_clk);
         check(shuttleFwd, 1'b0);
         btn[i] <= 1'b0;
         repeat (6) @(posedge ref_clk);
         check(shuttleFwd, 1'b1);
      end
      waitIdle();
      check(nStop, 1);
   endtask : yieldTest

   task automatic windowTest;
      logic [31:0] d;
      logic [1:0]  r;
      search(16'h1501);
      check(ctrlActive, 1'b0);
      axiRd(`TSC_OFF_STATUS, d, r);
      check(d[`TSC_ST_OUTWIN], 1'b1);
      axiWr(`TSC_OFF_STATUS, 32'h0000_0008, r);
      axiRd(`TSC_OFF_STATUS, d, r);
      check(d[`TSC_ST_OUTWIN], 1'b0);
      search(16'h1500);
      check(ctrlActive, 1'b1);
      axiWr(`TSC_OFF_CTRL, 32'h0000_0004, r);
      repeat (3) @(posedge ref_clk);
      check(ctrlActive, 1'b0);
   endtask : windowTest

   initial begin
      srst = 1'b1;
      slowTach = 1'b0;
      btn = 7'h00;
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
      {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = 52'h0;
      repeat (5) @(posedge ref_clk);
      srst <= 1'b0;
      @(posedge ref_clk);
      regsTest();
      fwdTest();
      playTest();
      stopTest();
      yieldTest();
      windowTest();
      results();
   end

   // Whole run is about 40k cycles of tape travel
   initial begin
      repeat (80000) @(posedge ref_clk);
      n_mismatch++;
      results();
   end
endmodule : test_tape_search_to_cue_controller
